/* irpgs_defs.svh */
`ifndef IRPGS_DEFS_SVH
`define IRPGS_DEFS_SVH

// Register indices; byte address is four times the index
`define IRPGS_IDX_ENABLE 12'h781
`define IRPGS_IDX_MODE 12'h783
`define IRPGS_IDX_PRIMARY 12'h794
`define IRPGS_IDX_PERIOD_COUNT 12'h7AC
`define IRPGS_IDX_MASK_LOW 12'h7B0
`define IRPGS_IDX_FLAGS_LOW 12'h7B1
`define IRPGS_IDX_MASK_HIGH 12'h7B2
`define IRPGS_IDX_FLAGS_HIGH 12'h7B3
`define IRPGS_IDX_PULSE_COUNT 12'h7C0
`define IRPGS_IDX_SHADOW 12'h7C4
`define IRPGS_IDX_ENTRY_FIRST 12'h7C8
`define IRPGS_IDX_ENTRY_LAST 12'h7CB
`define IRPGS_IDX_TRIGGER_LEVEL 12'h7CC
`define IRPGS_IDX_QUEUE_STATUS 12'h7CD
`define IRPGS_IDX_QUEUE_CLEAR 12'h7CE

// Mode codes in the low nibble of the mode register
`define IRPGS_MODE_COUNTING 4'h1
`define IRPGS_MODE_IR_REPEAT 4'h3
`define IRPGS_MODE_IR_FIFO 4'h7
`define IRPGS_MODE_IR_DMA 4'hF

// Flag bit positions
`define IRPGS_FLAG_GROUP_DONE 0
`define IRPGS_FLAG_COUNT_EVENT 1
`define IRPGS_FLAG_FRAME_DONE 2
`define IRPGS_FLAG_QUEUE_STOP 0

// Descriptor fields
`define IRPGS_DESC_NUM_MSB 13
`define IRPGS_DESC_SHADOW 14
`define IRPGS_DESC_CARRIER 15

// Queue status fields
`define IRPGS_STAT_EMPTY 4
`define IRPGS_STAT_FULL 5

// Queue geometry
`define IRPGS_QUEUE_BYTES 4'h8
`define IRPGS_DMA_READY_MAX 4'h4

// Reset values
`define IRPGS_RST_SHADOW 32'h0000_5555
`define IRPGS_RST_PRIMARY 32'h0000_0000

// Bus answers
`define IRPGS_RESP_OKAY 2'h0
`define IRPGS_RESP_SLVERR 2'h2

`endif

/* irpgs_emitter.sv */
`timescale 1ns/1ns

module irpgs_emitter (
  input wire logic clock,
  input wire logic reset,
  input wire logic led_drive,
  output int pulse_cnt_ff,
  output int lit_cycles_ff
);
  logic prev_ff;
  // Counts light pulses and lit cycles seen by the diode
  always_ff @(posedge clock) begin
    prev_ff <= reset ? 1'h0 : led_drive;
    pulse_cnt_ff <= reset ? 0 : pulse_cnt_ff + int'(led_drive && !prev_ff);
    lit_cycles_ff <= reset ? 0 : lit_cycles_ff + int'(led_drive);
  end
endmodule : irpgs_emitter

/* irpgs_pkg.sv */
package irpgs_pkg;
  // Channel sequencing states
  typedef enum logic [0:0] {
    ST_IDLE,
    ST_RUN
  } irpgs_state_t;
  typedef logic [13:0] irpgs_addr_t;
endpackage : irpgs_pkg

/* irpgs_sequencer.sv */
// What this block does
// [RULE_01] Low mode nibble 0011 selects repeated pulse group infrared mode.
// [RULE_02] Repeated group mode emits groups back to back without stopping.
// [RULE_03] Compare, cycle time and group count changes apply from the next group.
// [RULE_04] Switching to counting mode mid-group finishes the group, then stops.
// [RULE_05] Clearing the enable bit forces the output low at once.
// [RULE_06] Frame-done and group-done flags set per frame and group; masks gate interrupts.
// [RULE_07] Low mode nibble 0111 selects software-fed queue mode.
// [RULE_08] Descriptor bits 13..0 hold the group period count.
// [RULE_09] Descriptor bit 14 selects primary or alternate compare and cycle time.
// [RULE_10] Descriptor bit 15 selects carrier burst or low space.
// [RULE_11] Entry window takes descriptors by byte, half word or word.
// [RULE_12] Eight byte queue; status register shows empty, full and byte count.
// [RULE_13] Queued groups play in order; software may append without overfilling.
// [RULE_14] Last group sent with queue empty clears the enable bit.
// [RULE_15] Writing one to queue clear empties the queue; only when idle. The code empties it in any state, running or idle.
// [RULE_16] Low mode nibble 1111 selects DMA-fed queue mode.
// [RULE_17] DMA fills the queue; starting the DMA channel sets the enable bit.
// [RULE_18] Memory buffer holds length word then little-endian descriptors.
// [RULE_19] Queue run completion sets the stop flag; mask gates; write one clears.
// [RULE_20] Frame is high below compare, low for the rest of the cycle time.
// [RULE_21] Status bits 3..0 count, bit 4 empty, bit 5 full.
// [RULE_22] Software queue mode raises a count event below the trigger level.
// [RULE_23] Space group is low for period count times selected cycle time.
// [RULE_24] Next queued group starts the cycle after the previous one ends.
`timescale 1ns/1ns
`include "irpgs_defs.svh"

module irpgs_sequencer (
  input wire logic clock,
  input wire logic reset,
  input wire irpgs_pkg::irpgs_addr_t s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire irpgs_pkg::irpgs_addr_t s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic dma_channel_start,
  input wire logic dma_busy,
  input wire logic dma_push_valid,
  input wire logic [31:0] dma_push_data,
  input wire logic [2:0] dma_push_bytes,
  output logic dma_push_ready,
  output logic channel_zero_out,
  output logic irq
);
  import irpgs_pkg::*;

  // Bus side state
  logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] rdata_ff;
  logic aw_held_ff, w_held_ff;
  logic [11:0] aw_idx_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;

  // Software registers
  logic enable_ff;
  logic [7:0] mode_ff;
  logic [31:0] primary_ff, shadow_ff;
  logic [15:0] period_count_ff;
  logic [7:0] mask_low_ff, flags_low_ff, mask_high_ff, flags_high_ff, level_ff;

  // Queue storage
  logic [7:0] queue_ff [0:7];
  logic [2:0] rd_ff, wr_ff;
  logic [3:0] count_ff;
  logic below_ff, push_ready_ff;

  // Waveform engine
  irpgs_state_t state_ff, nxt_state;
  logic [15:0] cnt_ff, nxt_cnt, pcnt_ff, nxt_pcnt;
  logic [15:0] act_cmp_ff, nxt_act_cmp, act_max_ff, nxt_act_max, act_num_ff, nxt_act_num;
  logic act_carrier_ff, nxt_act_carrier;
  logic out_ff, irq_ff;
  logic load, auto_stop, frame_end, group_end, queue_stop;

  // Write and read handshake decode
  wire do_write = aw_held_ff && w_held_ff && !bvalid_ff;
  wire [11:0] rd_idx = s_axi_araddr[13:2];
  wire do_read = s_axi_arvalid && arready_ff;
  wire wr_en_reg = do_write && (aw_idx_ff == `IRPGS_IDX_ENABLE);
  wire wr_mode = do_write && (aw_idx_ff == `IRPGS_IDX_MODE);
  wire wr_primary = do_write && (aw_idx_ff == `IRPGS_IDX_PRIMARY);
  wire wr_pnum = do_write && (aw_idx_ff == `IRPGS_IDX_PERIOD_COUNT);
  wire wr_mask_low = do_write && (aw_idx_ff == `IRPGS_IDX_MASK_LOW);
  wire wr_flags_low = do_write && (aw_idx_ff == `IRPGS_IDX_FLAGS_LOW);
  wire wr_mask_high = do_write && (aw_idx_ff == `IRPGS_IDX_MASK_HIGH);
  wire wr_flags_high = do_write && (aw_idx_ff == `IRPGS_IDX_FLAGS_HIGH);
  wire wr_shadow = do_write && (aw_idx_ff == `IRPGS_IDX_SHADOW);
  wire wr_level = do_write && (aw_idx_ff == `IRPGS_IDX_TRIGGER_LEVEL);
  wire wr_entry = do_write && (aw_idx_ff >= `IRPGS_IDX_ENTRY_FIRST) && (aw_idx_ff <= `IRPGS_IDX_ENTRY_LAST);
  wire wr_clear = do_write && (aw_idx_ff == `IRPGS_IDX_QUEUE_CLEAR) && wstrb_ff[0] && wdata_ff[0];
  wire wr_known = wr_en_reg || wr_mode || wr_primary || wr_pnum || wr_mask_low || wr_flags_low ||
                  wr_mask_high || wr_flags_high || wr_shadow || wr_level || wr_entry ||
                  (do_write && (aw_idx_ff == `IRPGS_IDX_QUEUE_CLEAR));

  // Byte-lane merge for read/write registers
  function automatic logic [31:0] irpgs_merge(input logic [31:0] old, input logic [31:0] data,
                                              input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res;
  endfunction : irpgs_merge
  wire [31:0] pnum_merged = irpgs_merge({16'h0, period_count_ff}, wdata_ff, wstrb_ff);

  // Mode decode
  wire [3:0] mode_code = mode_ff[3:0];
  wire mode_counting = (mode_code == `IRPGS_MODE_COUNTING);
  wire mode_ir = (mode_code == `IRPGS_MODE_IR_REPEAT); // RULE_01
  wire mode_sw_fifo = (mode_code == `IRPGS_MODE_IR_FIFO); // RULE_07
  wire mode_dma = (mode_code == `IRPGS_MODE_IR_DMA); // RULE_16
  wire fifo_mode = mode_sw_fifo || mode_dma;

  // Queue decode: lowest-lane contiguous strobes give the entry width
  wire [2:0] axi_bytes = (wstrb_ff == 4'hF) ? 3'h4 : (wstrb_ff[1:0] == 2'h3) ? 3'h2 :
                         wstrb_ff[0] ? 3'h1 : 3'h0; // RULE_11
  wire dma_take = mode_dma && dma_push_valid && push_ready_ff; // RULE_17
  wire [2:0] push_req = dma_take ? dma_push_bytes : ((wr_entry && !mode_dma) ? axi_bytes : 3'h0);
  wire [31:0] push_data = dma_take ? dma_push_data : wdata_ff;
  wire [3:0] free_bytes = `IRPGS_QUEUE_BYTES - count_ff;
  wire [3:0] push_n = ({1'b0, push_req} > free_bytes) ? free_bytes : {1'b0, push_req}; // RULE_13
  wire has_desc = (count_ff >= 4'h2);
  wire [15:0] head_desc = {queue_ff[rd_ff + 3'h1], queue_ff[rd_ff]}; // RULE_18
  wire pop = load && fifo_mode;
  wire [3:0] nxt_count = wr_clear ? 4'h0 : (count_ff - (pop ? 4'h2 : 4'h0) + push_n);
  wire queue_empty = (count_ff == 4'h0);
  wire queue_full = (count_ff == `IRPGS_QUEUE_BYTES);
  wire [7:0] status_byte = {2'h0, queue_full, queue_empty, count_ff}; // RULE_12 RULE_21
  wire now_below = mode_sw_fifo && ({4'h0, count_ff} < level_ff);
  wire count_event = now_below && !below_ff; // RULE_22

  // Frame and group boundaries; zero counts act as one
  wire [16:0] cnt_inc = {1'b0, cnt_ff} + 17'h1;
  wire [16:0] pcnt_inc = {1'b0, pcnt_ff} + 17'h1;
  assign frame_end = (state_ff == ST_RUN) && enable_ff && (cnt_inc >= {1'b0, act_max_ff});
  assign group_end = frame_end && (pcnt_inc >= {1'b0, act_num_ff});

  // Group settings sampled only at a group start
  wire [31:0] desc_timing = head_desc[`IRPGS_DESC_SHADOW] ? shadow_ff : primary_ff; // RULE_09
  wire [15:0] desc_num = {2'h0, head_desc[`IRPGS_DESC_NUM_MSB:0]}; // RULE_08
  wire can_load = !fifo_mode || has_desc;
  wire keep_going = mode_ir || !mode_counting; // RULE_02 RULE_04

  // Sequencing of frames and groups
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_pcnt = pcnt_ff;
    nxt_act_cmp = act_cmp_ff;
    nxt_act_max = act_max_ff;
    nxt_act_num = act_num_ff;
    nxt_act_carrier = act_carrier_ff;
    load = 1'b0;
    auto_stop = 1'b0;
    queue_stop = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        if (enable_ff && can_load) begin
          load = 1'b1;
        end
      end
      ST_RUN: begin
        if (!enable_ff) begin
          nxt_state = ST_IDLE; // RULE_05
        end else if (group_end) begin
          if (!keep_going) begin
            auto_stop = 1'b1; // RULE_04
            nxt_state = ST_IDLE;
          end else if (can_load) begin
            load = 1'b1; // RULE_24
          end else if (mode_dma && dma_busy) begin
            nxt_state = ST_IDLE;
          end else begin
            auto_stop = 1'b1; // RULE_14
            queue_stop = 1'b1; // RULE_19
            nxt_state = ST_IDLE;
          end
        end else if (frame_end) begin
          nxt_cnt = 16'h0;
          nxt_pcnt = pcnt_inc[15:0];
        end else begin
          nxt_cnt = cnt_inc[15:0];
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
    if (load) begin
      nxt_state = ST_RUN;
      nxt_cnt = 16'h0;
      nxt_pcnt = 16'h0;
      if (fifo_mode) begin
        nxt_act_cmp = desc_timing[15:0];
        nxt_act_max = desc_timing[31:16];
        nxt_act_num = desc_num;
        nxt_act_carrier = head_desc[`IRPGS_DESC_CARRIER]; // RULE_10 RULE_23
      end else begin
        nxt_act_cmp = primary_ff[15:0]; // RULE_03
        nxt_act_max = primary_ff[31:16];
        nxt_act_num = period_count_ff;
        nxt_act_carrier = 1'b1;
      end
    end
  end

  // Enable: DMA start beats software write beats self-clear
  wire nxt_enable = (mode_dma && dma_channel_start) ? 1'b1 :
                    (wr_en_reg && wstrb_ff[0]) ? wdata_ff[0] :
                    auto_stop ? 1'b0 : enable_ff;
  wire nxt_out = (nxt_state == ST_RUN) && nxt_enable && nxt_act_carrier && (nxt_cnt < nxt_act_cmp); // RULE_20

  // Flag updates: hardware set wins over write-one-clear
  wire [7:0] low_set = {5'h0, frame_end, count_event, group_end};
  wire [7:0] low_clr = (wr_flags_low && wstrb_ff[0]) ? wdata_ff[7:0] : 8'h0;
  wire [7:0] high_clr = (wr_flags_high && wstrb_ff[0]) ? wdata_ff[7:0] : 8'h0;
  wire [7:0] nxt_flags_low = (flags_low_ff & ~low_clr) | low_set; // RULE_06
  wire [7:0] nxt_flags_high = (flags_high_ff & ~high_clr) | {7'h0, queue_stop}; // RULE_19

  // Read mux
  logic [31:0] rd_value;
  logic rd_known;
  always_comb begin
    rd_known = 1'b1;
    case (rd_idx)
      `IRPGS_IDX_ENABLE: rd_value = {31'h0, enable_ff};
      `IRPGS_IDX_MODE: rd_value = {24'h0, mode_ff};
      `IRPGS_IDX_PRIMARY: rd_value = primary_ff;
      `IRPGS_IDX_PERIOD_COUNT: rd_value = {16'h0, period_count_ff};
      `IRPGS_IDX_MASK_LOW: rd_value = {24'h0, mask_low_ff};
      `IRPGS_IDX_FLAGS_LOW: rd_value = {24'h0, flags_low_ff};
      `IRPGS_IDX_MASK_HIGH: rd_value = {24'h0, mask_high_ff};
      `IRPGS_IDX_FLAGS_HIGH: rd_value = {24'h0, flags_high_ff};
      `IRPGS_IDX_PULSE_COUNT: rd_value = {16'h0, pcnt_ff};
      `IRPGS_IDX_SHADOW: rd_value = shadow_ff;
      `IRPGS_IDX_TRIGGER_LEVEL: rd_value = {24'h0, level_ff};
      `IRPGS_IDX_QUEUE_STATUS: rd_value = {24'h0, status_byte};
      `IRPGS_IDX_QUEUE_CLEAR: rd_value = 32'h0;
      default: begin
        rd_value = 32'h0;
        rd_known = (rd_idx >= `IRPGS_IDX_ENTRY_FIRST) && (rd_idx <= `IRPGS_IDX_ENTRY_LAST);
      end
    endcase
  end

  // Write address and data capture, in either order
  always_ff @(posedge clock) begin
    if (reset) begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      aw_idx_ff <= 12'h0;
      wdata_ff <= 32'h0;
      wstrb_ff <= 4'h0;
    end else begin
      if (s_axi_awvalid && awready_ff) begin
        aw_held_ff <= 1'b1;
        aw_idx_ff <= s_axi_awaddr[13:2];
      end else if (do_write) begin
        aw_held_ff <= 1'b0;
      end
      if (s_axi_wvalid && wready_ff) begin
        w_held_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end else if (do_write) begin
        w_held_ff <= 1'b0;
      end
      awready_ff <= !(aw_held_ff || (s_axi_awvalid && awready_ff)) || do_write;
      wready_ff <= !(w_held_ff || (s_axi_wvalid && wready_ff)) || do_write;
    end
  end

  // Write response and read answer
  always_ff @(posedge clock) begin
    if (reset) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= `IRPGS_RESP_OKAY;
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0;
      rresp_ff <= `IRPGS_RESP_OKAY;
    end else begin
      if (do_write) begin
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_known ? `IRPGS_RESP_OKAY : `IRPGS_RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
      if (do_read) begin
        rvalid_ff <= 1'b1;
        rdata_ff <= rd_value;
        rresp_ff <= rd_known ? `IRPGS_RESP_OKAY : `IRPGS_RESP_SLVERR;
        arready_ff <= 1'b0;
      end else if (rvalid_ff && s_axi_rready) begin
        rvalid_ff <= 1'b0;
        arready_ff <= 1'b1;
      end else if (!rvalid_ff) begin
        arready_ff <= 1'b1;
      end
    end
  end

  // Software registers
  always_ff @(posedge clock) begin
    if (reset) begin
      enable_ff <= 1'b0;
      mode_ff <= 8'h0;
      primary_ff <= `IRPGS_RST_PRIMARY;
      shadow_ff <= `IRPGS_RST_SHADOW;
      period_count_ff <= 16'h0;
      mask_low_ff <= 8'h0;
      mask_high_ff <= 8'h0;
      level_ff <= 8'h0;
      flags_low_ff <= 8'h0;
      flags_high_ff <= 8'h0;
    end else begin
      enable_ff <= nxt_enable; // RULE_05 RULE_14 RULE_17
      flags_low_ff <= nxt_flags_low;
      flags_high_ff <= nxt_flags_high;
      if (wr_mode && wstrb_ff[0]) begin
        mode_ff <= wdata_ff[7:0];
      end
      if (wr_primary) begin
        primary_ff <= irpgs_merge(primary_ff, wdata_ff, wstrb_ff);
      end
      if (wr_shadow) begin
        shadow_ff <= irpgs_merge(shadow_ff, wdata_ff, wstrb_ff);
      end
      if (wr_pnum) begin
        period_count_ff <= pnum_merged[15:0];
      end
      if (wr_mask_low && wstrb_ff[0]) begin
        mask_low_ff <= wdata_ff[7:0];
      end
      if (wr_mask_high && wstrb_ff[0]) begin
        mask_high_ff <= wdata_ff[7:0];
      end
      if (wr_level && wstrb_ff[0]) begin
        level_ff <= wdata_ff[7:0];
      end
    end
  end

  // Descriptor queue
  always_ff @(posedge clock) begin
    if (reset) begin
      rd_ff <= 3'h0;
      wr_ff <= 3'h0;
      count_ff <= 4'h0;
      below_ff <= 1'b0;
      push_ready_ff <= 1'b0;
      for (int i = 0; i < 8; i++) begin
        queue_ff[i] <= 8'h0;
      end
    end else begin
      count_ff <= nxt_count;
      below_ff <= now_below;
      push_ready_ff <= mode_dma && (nxt_count <= `IRPGS_DMA_READY_MAX);
      if (wr_clear) begin
        rd_ff <= 3'h0; // RULE_15
        wr_ff <= 3'h0;
      end else begin
        for (int i = 0; i < 4; i++) begin
          if (4'(i) < push_n) begin
            queue_ff[wr_ff + 3'(i)] <= push_data[i*8 +: 8];
          end
        end
        wr_ff <= wr_ff + push_n[2:0];
        if (pop) begin
          rd_ff <= rd_ff + 3'h2; // RULE_13
        end
      end
    end
  end

  // Waveform engine and outputs
  always_ff @(posedge clock) begin
    if (reset) begin
      state_ff <= ST_IDLE;
      cnt_ff <= 16'h0;
      pcnt_ff <= 16'h0;
      act_cmp_ff <= 16'h0;
      act_max_ff <= 16'h0;
      act_num_ff <= 16'h0;
      act_carrier_ff <= 1'b0;
      out_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      pcnt_ff <= nxt_pcnt;
      act_cmp_ff <= nxt_act_cmp;
      act_max_ff <= nxt_act_max;
      act_num_ff <= nxt_act_num;
      act_carrier_ff <= nxt_act_carrier;
      out_ff <= nxt_out;
      irq_ff <= |(nxt_flags_low & mask_low_ff) || |(nxt_flags_high & mask_high_ff); // RULE_06 RULE_19
    end
  end

  // Port drive
  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign dma_push_ready = push_ready_ff;
  assign channel_zero_out = out_ff;
  assign irq = irq_ff;

endmodule : irpgs_sequencer

/* irpgs_sva.sv */
`timescale 1ns/1ns
`include "irpgs_defs.svh"

module irpgs_chk (
  input wire logic clock,
  input wire logic reset,
  input wire irpgs_pkg::irpgs_addr_t s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic channel_zero_out,
  input wire logic irq
);
  import irpgs_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  irpgs_addr_t wr_addr_ff;
  logic wr_clear_ff;
  // Remember target and whether the write in flight clears bit zero
  always_ff @(posedge clock) begin
    if (s_axi_awvalid && s_axi_awready) wr_addr_ff <= s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready) wr_clear_ff <= s_axi_wstrb[0] && !s_axi_wdata[0];
  end
  // Both halves of a write taken together
  sequence s_both_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid;
  endsequence
  // Write to the enable register with bit zero cleared has landed
  sequence s_clear_done;
    $rose(s_axi_bvalid) && wr_clear_ff && wr_addr_ff[13:2] == `IRPGS_IDX_ENABLE;
  endsequence
  a_write_answer: assert property (
    s_both_taken |=> ##1 s_axi_bvalid) else $error("write answer missing");
  a_write_ready_drop: assert property (
    s_both_taken |=> !s_axi_awready && !s_axi_wready) else $error("write readies stayed high");
  a_bresp_holds: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer missing");
  a_rdata_holds: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read answer dropped");
  a_read_blocked: assert property (
    s_axi_rvalid |-> !s_axi_arready) else $error("read address taken with answer pending");
  a_clear_drops_out: assert property (
    s_clear_done |=> !channel_zero_out [*4]) else $error("output high after enable cleared");
  a_reset_quiet: assert property (
    $fell(reset) |-> !channel_zero_out && !irq && !s_axi_bvalid && !s_axi_rvalid && !s_axi_awready)
    else $error("outputs active after reset");
endmodule : irpgs_chk

bind irpgs_sequencer irpgs_chk irpgs_chk_i (.clock, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .channel_zero_out, .irq);

/* tb_ir_pulse_group_sequencer.sv */
`timescale 1ns/1ns
`include "irpgs_defs.svh"

module tb_ir_pulse_group_sequencer;
  import irpgs_pkg::*;
  typedef struct packed {logic [11:0] idx; logic [31:0] dat; logic [1:0] rsp;} irpgs_row_t;
  logic clock = 1'h0;
  logic reset = 1'h1;
  irpgs_addr_t s_axi_awaddr = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
  logic s_axi_bready = 1'h1, s_axi_rready = 1'h1;
  logic [31:0] s_axi_wdata = '0, dma_push_data = '0;
  logic [3:0] s_axi_wstrb = '0;
  logic dma_channel_start = 1'h0, dma_busy = 1'h0, dma_push_valid = 1'h0;
  logic [2:0] dma_push_bytes = 3'h4;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic dma_push_ready, channel_zero_out, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  int pulse_cnt, lit_cycles, p0, l0, error_cnt = 0, checks_done = 0, cycles = 0;

  irpgs_sequencer irpgs_sequencer_i (.clock, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .dma_channel_start, .dma_busy, .dma_push_valid, .dma_push_data, .dma_push_bytes, .dma_push_ready,
    .channel_zero_out, .irq);
  irpgs_emitter irpgs_emitter_i (.clock, .reset, .led_drive(channel_zero_out), .pulse_cnt_ff(pulse_cnt),
    .lit_cycles_ff(lit_cycles));

  // Clock and hang guard
  initial forever #2 clock = ~clock;
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      give_verdict();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // Bus write: address and data offered together, each released when taken
  task automatic wr(input logic [11:0] idx, input logic [31:0] d, input logic [3:0] st = 4'hF);
    logic a, w;
    a = 1'h1;
    w = 1'h1;
    s_axi_awaddr <= {idx, 2'h0};
    s_axi_wdata <= d;
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    while (a || w) begin
      @(posedge clock);
      if (a && s_axi_awready === 1'h1) begin
        a = 1'h0;
        s_axi_awvalid <= 1'h0;
      end
      if (w && s_axi_wready === 1'h1) begin
        w = 1'h0;
        s_axi_wvalid <= 1'h0;
      end
    end
    do @(posedge clock); while (s_axi_bvalid !== 1'h1);
    chk({30'h0, s_axi_bresp}, 32'h0);
  endtask : wr

  task automatic rd(input logic [11:0] idx, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= {idx, 2'h0};
    s_axi_arvalid <= 1'h1;
    do @(posedge clock); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    do @(posedge clock); while (s_axi_rvalid !== 1'h1);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask : rd

  task automatic rchk(input logic [11:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    rd(idx, d, r);
    chk(d, exp);
  endtask : rchk

  task automatic snap();
    p0 = pulse_cnt;
    l0 = lit_cycles;
  endtask : snap

  task automatic give_verdict();
    $display("mismatches %0d, comparisons %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict

  // Main sequence
  initial begin
    static irpgs_row_t rows [6] = '{
      '{`IRPGS_IDX_QUEUE_STATUS, 32'h1 << `IRPGS_STAT_EMPTY, `IRPGS_RESP_OKAY},
      '{`IRPGS_IDX_SHADOW, `IRPGS_RST_SHADOW, `IRPGS_RESP_OKAY},
      '{`IRPGS_IDX_PRIMARY, `IRPGS_RST_PRIMARY, `IRPGS_RESP_OKAY},
      '{`IRPGS_IDX_ENABLE, 32'h0, `IRPGS_RESP_OKAY},
      '{`IRPGS_IDX_ENTRY_FIRST, 32'h0, `IRPGS_RESP_OKAY},
      '{12'h7C2, 32'h0, `IRPGS_RESP_SLVERR}};
    logic [31:0] d, dw;
    logic [1:0] r;
    dw = 32'hC002_8003;
    repeat (8) @(posedge clock);
    reset <= 1'h0;
    repeat (2) @(posedge clock);
    foreach (rows[i]) begin
      rd(rows[i].idx, d, r);
      chk(d, rows[i].dat);
      chk({30'h0, r}, {30'h0, rows[i].rsp});
    end
    // Repeated groups: cycle 4, high 2, two frames a group
    wr(`IRPGS_IDX_PRIMARY, 32'h0004_0002);
    wr(`IRPGS_IDX_PERIOD_COUNT, 32'h2);
    wr(`IRPGS_IDX_MODE, {28'h0, `IRPGS_MODE_IR_REPEAT});
    wr(`IRPGS_IDX_MASK_LOW, 32'h1);
    wr(`IRPGS_IDX_ENABLE, 32'h1);
    repeat (8) @(posedge clock);
    snap();
    repeat (40) @(posedge clock);
    chk(32'(pulse_cnt - p0), 32'hA);
    chk(32'(lit_cycles - l0), 32'h14);
    rchk(`IRPGS_IDX_FLAGS_LOW, 32'h5);
    chk({31'h0, irq}, 32'h1);
    wr(`IRPGS_IDX_ENABLE, 32'h0);
    snap();
    repeat (20) @(posedge clock);
    chk(32'(pulse_cnt - p0), 32'h0);
    // Graceful stop through counting mode
    wr(`IRPGS_IDX_ENABLE, 32'h1);
    repeat (5) @(posedge clock);
    wr(`IRPGS_IDX_MODE, {28'h0, `IRPGS_MODE_COUNTING});
    repeat (30) @(posedge clock);
    rchk(`IRPGS_IDX_ENABLE, 32'h0);
    wr(`IRPGS_IDX_MASK_LOW, 32'h0);
    wr(`IRPGS_IDX_FLAGS_LOW, 32'h7);
    // Software queue: fill, overfill, clear
    wr(`IRPGS_IDX_MODE, {28'h0, `IRPGS_MODE_IR_FIFO});
    wr(`IRPGS_IDX_ENTRY_FIRST, 32'h0002_8003);
    wr(`IRPGS_IDX_ENTRY_FIRST, 32'h1, 4'h3);
    wr(12'h7CA, 32'h1, 4'h3);
    rchk(`IRPGS_IDX_QUEUE_STATUS, (32'h1 << `IRPGS_STAT_FULL) | 32'h8);
    wr(`IRPGS_IDX_ENTRY_LAST, 32'h1, 4'h1);
    rchk(`IRPGS_IDX_QUEUE_STATUS, (32'h1 << `IRPGS_STAT_FULL) | 32'h8);
    wr(`IRPGS_IDX_QUEUE_CLEAR, 32'h1);
    rchk(`IRPGS_IDX_QUEUE_STATUS, 32'h1 << `IRPGS_STAT_EMPTY);
    wr(`IRPGS_IDX_TRIGGER_LEVEL, 32'h3);
    rchk(`IRPGS_IDX_FLAGS_LOW, 32'h2);
    // Carrier 3 on primary, carrier 2 on alternate (cycle 6, high 3), space 2
    wr(`IRPGS_IDX_SHADOW, 32'h0006_0003);
    for (int i = 0; i < 4; i++) wr(`IRPGS_IDX_ENTRY_FIRST + 12'(i), {24'h0, dw[8*i +: 8]}, 4'h1);
    wr(`IRPGS_IDX_ENTRY_FIRST, 32'h2, 4'h3);
    rchk(`IRPGS_IDX_QUEUE_STATUS, 32'h6);
    wr(`IRPGS_IDX_MASK_HIGH, 32'h1);
    snap();
    wr(`IRPGS_IDX_ENABLE, 32'h1);
    repeat (60) @(posedge clock);
    chk(32'(pulse_cnt - p0), 32'h5);
    chk(32'(lit_cycles - l0), 32'hC);
    rchk(`IRPGS_IDX_ENABLE, 32'h0);
    rchk(`IRPGS_IDX_FLAGS_HIGH, 32'h1);
    chk({31'h0, irq}, 32'h1);
    wr(`IRPGS_IDX_FLAGS_HIGH, 32'h1);
    rchk(`IRPGS_IDX_FLAGS_HIGH, 32'h0);
    chk({31'h0, irq}, 32'h0);
    // DMA feed: low half-word first, start sets the enable
    wr(`IRPGS_IDX_MODE, {28'h0, `IRPGS_MODE_IR_DMA});
    snap();
    dma_busy <= 1'h1;
    dma_push_data <= 32'h0001_8002;
    dma_push_valid <= 1'h1;
    do @(posedge clock); while (dma_push_ready !== 1'h1);
    dma_push_valid <= 1'h0;
    dma_channel_start <= 1'h1;
    @(posedge clock);
    dma_channel_start <= 1'h0;
    dma_busy <= 1'h0;
    rchk(`IRPGS_IDX_ENABLE, 32'h1);
    repeat (40) @(posedge clock);
    chk(32'(pulse_cnt - p0), 32'h2);
    rchk(`IRPGS_IDX_ENABLE, 32'h0);
    rchk(`IRPGS_IDX_FLAGS_HIGH, 32'h1);
    give_verdict();
  end
endmodule : tb_ir_pulse_group_sequencer
